// file: twl_pkg.sv
// Purpose: constants for the table write / latch read execution block
// Assumes: 16-bit instruction words, 8-bit file registers, 16-bit table pointer
// Notes: opcode prefixes compared against instr[15:10]
package twl_pkg;
  localparam logic [5:0] TWL_WRITE_PREFIX = 6'h2B;  // 1010 11ti
  localparam logic [5:0] TWL_LREAD_PREFIX = 6'h28;  // 1010 00tx
  localparam int TWL_T_BIT = 9;
  localparam int TWL_I_BIT = 8;
  localparam logic [15:0] TWL_LATCH_RST = 16'h0000;
  localparam logic [15:0] TWL_PTR_RST = 16'h0000;
  localparam logic [15:0] TWL_EXT_BASE = 16'h1000;
  typedef enum logic [1:0] {
    TWL_IDLE,
    TWL_EXT_WR,
    TWL_INT_WR
  } twl_state_type;
endpackage

// file: twl_table_write_latch_read.sv
// Purpose: executes table write and latch read instructions of the core
// Assumes: one instruction offered per instr_valid_i pulse while ready is high
// Notes: program memory is outside; writes handed over on pm_wr_* ports
//
// How it works
// - table write opcode 1010 11ti ffff ffff
// - t selects low or high latch byte
// - whole latch written at table pointer address
// - i set increments pointer after write
// - external memory write takes two cycles
// - internal EPROM write ends on interrupt
// - low programming voltage still runs sequence
// - latch read copies latch byte to file
// - t=1 high byte, t=0 low byte
// - latch read leaves latch unchanged
// - latch read moves table read data
`timescale 1ns/1ns
module twl_table_write_latch_read
  import twl_pkg::*;
#(
  parameter logic [15:0] EXT_BASE = TWL_EXT_BASE
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // instruction issue
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  output logic ready_o,
  // file register data read by the core for operand f
  input wire logic [7:0] file_data_i,
  // table read capture from program memory, and pointer load
  input wire logic table_read_op_i,
  input wire logic [15:0] table_read_data_i,
  input wire logic table_read_inc_i,
  input wire logic ptr_load_i,
  input wire logic [15:0] ptr_load_data_i,
  // program memory write side
  output logic pm_wr_o,
  output logic pm_wr_internal_o,
  output logic [15:0] pm_addr_o,
  output logic [15:0] pm_data_o,
  input wire logic irq_i,
  input wire logic clear_and_program_voltage_pin_i,
  // file register write back
  output logic file_we_o,
  output logic [7:0] file_addr_o,
  output logic [7:0] file_data_o,
  // status
  output logic [15:0] table_latch_o,
  output logic [15:0] table_pointer_o,
  output logic prog_voltage_low_o,
  output logic done_o
);
  twl_state_type state_q, state_d;
  logic [7:0] table_latch_high_q, table_latch_high_d;
  logic [7:0] table_latch_low_q, table_latch_low_d;
  logic [15:0] table_pointer_q, table_pointer_d;
  logic inc_q, inc_d;
  logic pm_wr_q, pm_wr_d;
  logic pm_int_q, pm_int_d;
  logic [15:0] pm_addr_q, pm_addr_d;
  logic [15:0] pm_data_q, pm_data_d;
  logic file_we_q, file_we_d;
  logic [7:0] file_addr_q, file_addr_d;
  logic [7:0] file_data_q, file_data_d;
  logic vlow_q, vlow_d;
  logic done_q, done_d;
  logic is_write, is_lread, t_sel;
  logic [15:0] new_latch;
  logic to_internal, write_end;

  assign ready_o = (state_q == TWL_IDLE);
  assign is_write = instr_valid_i && ready_o && (instr_i[15:10] == TWL_WRITE_PREFIX);
  assign is_lread = instr_valid_i && ready_o && (instr_i[15:10] == TWL_LREAD_PREFIX);
  assign t_sel = instr_i[TWL_T_BIT];
  // below the external base is on-chip EPROM
  assign to_internal = (table_pointer_q < EXT_BASE);
  // pointer steps only once the write is over, so the strobe sees a steady address
  assign write_end = (state_q == TWL_EXT_WR) || ((state_q == TWL_INT_WR) && irq_i);
  assign new_latch = t_sel ? {file_data_i, table_latch_low_q} :
    {table_latch_high_q, file_data_i};

  // write sequencing: one strobe cycle off chip, a held strobe on chip
  always_comb begin
    state_d = state_q;
    inc_d = inc_q;
    pm_wr_d = 1'b0;
    pm_int_d = pm_int_q;
    pm_addr_d = pm_addr_q;
    pm_data_d = pm_data_q;
    vlow_d = vlow_q;
    done_d = 1'b0;
    case (state_q)
      TWL_IDLE: begin
        if (is_write) begin
          pm_addr_d = table_pointer_q;
          pm_data_d = new_latch;
          pm_wr_d = 1'b1;
          inc_d = instr_i[TWL_I_BIT];
          pm_int_d = to_internal;
          // sequence runs regardless of pin; the flag reports likely failure
          vlow_d = to_internal && !clear_and_program_voltage_pin_i;
          state_d = to_internal ? TWL_INT_WR : TWL_EXT_WR;
        end else if (is_lread) begin
          done_d = 1'b1;
        end
      end
      TWL_EXT_WR: begin
        done_d = 1'b1;
        state_d = TWL_IDLE;
      end
      TWL_INT_WR: begin
        // no cycle limit here: a missing interrupt keeps the block busy
        pm_wr_d = !irq_i;
        if (irq_i) begin
          done_d = 1'b1;
          state_d = TWL_IDLE;
        end
      end
      default: begin
        state_d = TWL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= TWL_IDLE;
      inc_q <= 1'b0;
      pm_wr_q <= 1'b0;
      pm_int_q <= 1'b0;
      pm_addr_q <= 16'h0000;
      pm_data_q <= 16'h0000;
      vlow_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      inc_q <= inc_d;
      pm_wr_q <= pm_wr_d;
      pm_int_q <= pm_int_d;
      pm_addr_q <= pm_addr_d;
      pm_data_q <= pm_data_d;
      vlow_q <= vlow_d;
      done_q <= done_d;
    end
  end

  // table read capture fills the latch that a latch read later drains
  always_comb begin
    table_latch_high_d = table_latch_high_q;
    table_latch_low_d = table_latch_low_q;
    if (table_read_op_i && ready_o) begin
      table_latch_high_d = table_read_data_i[15:8];
      table_latch_low_d = table_read_data_i[7:0];
    end
    // of the two instructions only a table write loads a byte; a latch read leaves both alone
    if (is_write) begin
      table_latch_high_d = new_latch[15:8];
      table_latch_low_d = new_latch[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      table_latch_high_q <= TWL_LATCH_RST[15:8];
      table_latch_low_q <= TWL_LATCH_RST[7:0];
    end else begin
      table_latch_high_q <= table_latch_high_d;
      table_latch_low_q <= table_latch_low_d;
    end
  end

  // pointer: load and table read step while idle, optional step after a write
  always_comb begin
    table_pointer_d = table_pointer_q;
    if (ptr_load_i && ready_o) begin
      table_pointer_d = ptr_load_data_i;
    end
    if (table_read_op_i && ready_o && table_read_inc_i) begin
      table_pointer_d = table_pointer_q + 16'h0001;
    end
    if (write_end && inc_q) begin
      table_pointer_d = table_pointer_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      table_pointer_q <= TWL_PTR_RST;
    end else begin
      table_pointer_q <= table_pointer_d;
    end
  end

  // file write-back; no status flag exists here, so none is ever touched
  always_comb begin
    file_we_d = 1'b0;
    file_addr_d = file_addr_q;
    file_data_d = file_data_q;
    if (is_lread) begin
      file_data_d = t_sel ? table_latch_high_q : table_latch_low_q;
      file_addr_d = instr_i[7:0];
      file_we_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      file_we_q <= 1'b0;
      file_addr_q <= 8'h00;
      file_data_q <= 8'h00;
    end else begin
      file_we_q <= file_we_d;
      file_addr_q <= file_addr_d;
      file_data_q <= file_data_d;
    end
  end

  assign pm_wr_o = pm_wr_q;
  assign pm_wr_internal_o = pm_int_q;
  assign pm_addr_o = pm_addr_q;
  assign pm_data_o = pm_data_q;
  assign file_we_o = file_we_q;
  assign file_addr_o = file_addr_q;
  assign file_data_o = file_data_q;
  assign table_latch_o = {table_latch_high_q, table_latch_low_q};
  assign table_pointer_o = table_pointer_q;
  assign prog_voltage_low_o = vlow_q;
  assign done_o = done_q;
endmodule

// file: twl_chk.sv
// Purpose: port assertions for the table write and latch read block
// Assumes: default split between internal and external memory
// Notes: one clock domain, so default clocking and disable
`timescale 1ns/1ns
module twl_chk
  import twl_pkg::*;
(
  // clock, reset, issue
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ready_o,
  // program memory side
  input wire logic pm_wr_o,
  input wire logic pm_wr_internal_o,
  input wire logic [15:0] pm_data_o,
  input wire logic irq_i,
  // file side and state
  input wire logic file_we_o,
  input wire logic [7:0] file_data_o,
  input wire logic done_o,
  input wire logic [15:0] table_latch_o,
  input wire logic [15:0] table_pointer_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_lr; instr_valid_i && ready_o && instr_i[15:10] == TWL_LREAD_PREFIX; endsequence
  sequence s_wr; instr_valid_i && ready_o && instr_i[15:10] == TWL_WRITE_PREFIX; endsequence
  sequence s_iw; pm_wr_o && pm_wr_internal_o; endsequence
  property p_lr_done; s_lr |=> file_we_o && done_o && ready_o; endproperty
  a_lr_done: assert property (p_lr_done) else $error("latch read late");
  property p_lr_keep; s_lr |=> $stable(table_latch_o); endproperty
  a_lr_keep: assert property (p_lr_keep) else $error("latch changed");
  property p_lr_byte;
    s_lr |=> file_data_o == ($past(instr_i[9]) ? $past(table_latch_o[15:8]) :
      $past(table_latch_o[7:0]));
  endproperty
  a_lr_byte: assert property (p_lr_byte) else $error("wrong latch byte");
  property p_wr_busy; s_wr |=> pm_wr_o && !ready_o; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write not started");
  property p_ext;
    s_wr and (table_pointer_o >= TWL_EXT_BASE) |=> ##1 done_o && !pm_wr_o;
  endproperty
  a_ext: assert property (p_ext) else $error("external write not two cycles");
  property p_data; $rose(pm_wr_o) |-> pm_data_o == table_latch_o; endproperty
  a_data: assert property (p_data) else $error("write data not latch");
  property p_int_hold; s_iw and !irq_i |=> pm_wr_o; endproperty
  a_int_hold: assert property (p_int_hold) else $error("internal write dropped");
  property p_int_end; s_iw and irq_i |=> done_o && !pm_wr_o; endproperty
  a_int_end: assert property (p_int_end) else $error("internal write not ended");
endmodule
bind twl_table_write_latch_read twl_chk i_chk (.ref_clk_i, .rst_b_i, .instr_valid_i, .instr_i,
  .ready_o, .pm_wr_o, .pm_wr_internal_o, .pm_data_o, .irq_i, .file_we_o, .file_data_o, .done_o,
  .table_latch_o, .table_pointer_o);

// file: twl_pm_model.sv
// Purpose: program memory and interrupt source beside the block
// Assumes: an internal write is ended by one interrupt pulse
// Notes: delay_i sets how slowly the interrupt comes
`timescale 1ns/1ns
module twl_pm_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic pm_wr_i,
  input wire logic pm_internal_i,
  input wire logic [15:0] pm_addr_i,
  input wire logic [15:0] pm_data_i,
  input wire logic [3:0] delay_i,
  output logic irq_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_data_o
);
  logic [3:0] cnt;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 4'h0;
      irq_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_data_o <= 16'h0000;
    end else begin
      if (pm_wr_i) begin
        mem_addr_o <= pm_addr_i;
        mem_data_o <= pm_data_i;
      end
      cnt <= (pm_wr_i && pm_internal_i) ? cnt + 4'h1 : 4'h0;
      irq_o <= pm_wr_i && pm_internal_i && cnt == delay_i;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: directed bench for table write and latch read
// Assumes: pointer at or above the default base is external
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import twl_pkg::*;
  logic ref_clk_i = 0, rst_b_i = 0, instr_valid_i = 0, table_read_op_i = 0, table_read_inc_i = 0;
  logic ptr_load_i = 0, irq_i, clear_and_program_voltage_pin_i = 1;
  logic [15:0] instr_i = 0, table_read_data_i = 0, ptr_load_data_i = 0, mem_addr, mem_data;
  logic [7:0] file_data_i = 0, file_addr_o, file_data_o;
  logic ready_o, pm_wr_o, pm_wr_internal_o, file_we_o, prog_voltage_low_o, done_o;
  logic [15:0] pm_addr_o, pm_data_o, table_latch_o, table_pointer_o;
  logic [3:0] delay = 4'h5;
  int miscompares = 0, checks_done = 0, n;
  always #2 ref_clk_i = ~ref_clk_i;
  twl_table_write_latch_read i_dut (.ref_clk_i, .rst_b_i, .instr_valid_i, .instr_i, .ready_o,
    .file_data_i, .table_read_op_i, .table_read_data_i, .table_read_inc_i, .ptr_load_i,
    .ptr_load_data_i, .pm_wr_o, .pm_wr_internal_o, .pm_addr_o, .pm_data_o, .irq_i,
    .clear_and_program_voltage_pin_i, .file_we_o, .file_addr_o, .file_data_o, .table_latch_o,
    .table_pointer_o, .prog_voltage_low_o, .done_o);
  twl_pm_model i_pm (.ref_clk_i, .rst_b_i, .pm_wr_i(pm_wr_o), .pm_internal_i(pm_wr_internal_o),
    .pm_addr_i(pm_addr_o), .pm_data_i(pm_data_o), .delay_i(delay), .irq_o(irq_i),
    .mem_addr_o(mem_addr), .mem_data_o(mem_data));
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // issue one word, then count cycles until done, bounded
  task automatic run(input logic [15:0] w, input logic [7:0] f);
    @(negedge ref_clk_i);
    {instr_i, file_data_i, instr_valid_i} = {w, f, 1'b1};
    @(negedge ref_clk_i);
    instr_valid_i = 0;
    n = 1;
    while (done_o !== 1'b1) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 20) begin
        miscompares++;
        test_done();
      end
    end
  endtask
  task automatic load_ptr(input logic [15:0] p);
    @(negedge ref_clk_i);
    {ptr_load_data_i, ptr_load_i} = {p, 1'b1};
    @(negedge ref_clk_i);
    ptr_load_i = 0;
  endtask
  task automatic s_ext;
    load_ptr(16'hA356);
    run(16'hAD12, 8'h53);
    `CHK(n, 2)
    `CHK(mem_data, 16'h0053)
    `CHK(prog_voltage_low_o, 1'b0)
    `CHK(table_pointer_o, 16'hA357)
    run(16'hAE34, 8'hAA);
    `CHK(mem_data, 16'hAA53)
    `CHK(mem_addr, 16'hA357)
    `CHK(table_pointer_o, 16'hA357)
  endtask
  task automatic s_int;
    load_ptr(16'h0010);
    clear_and_program_voltage_pin_i = 0;
    run(16'hAC01, 8'h77);
    `CHK(n, 8)
    `CHK(prog_voltage_low_o, 1'b1)
    `CHK(mem_data, 16'hAA77)
  endtask
  task automatic s_lr;
    @(negedge ref_clk_i);
    {table_read_data_i, table_read_op_i, table_read_inc_i} = {16'hB7C4, 2'h3};
    @(negedge ref_clk_i);
    {table_read_op_i, table_read_inc_i} = 2'h0;
    `CHK(table_pointer_o, 16'h0011)
    run(16'hA20F, 8'h00);
    `CHK(n, 1)
    `CHK(file_data_o, 8'hB7)
    run(16'hA1F0, 8'h00);
    `CHK({file_addr_o, file_data_o}, 16'hF0C4)
    `CHK(table_latch_o, 16'hB7C4)
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_b_i = 1;
    s_ext();
    s_int();
    s_lr();
    test_done();
  end
endmodule
